/* spamx_pkg.sv */
// Package for the serial port A pin multiplexer: per-pin function codes,
// reset values and timing counts.
// Assumes a single 200 MHz core clock; no software-visible register map.
package spamx_pkg;
	// Pin indices of the four port pins
	localparam int PIN_OUT   = 0;
	localparam int PIN_IN    = 1;
	localparam int PIN_REQ   = 2;
	localparam int PIN_CLEAR = 3;
	localparam int NUM_PINS  = 4;

	// Per-pin normal-mode programming (2 bits each)
	typedef enum logic [1:0] {
		SPAMX_FN_GPIO    = 2'h0,
		SPAMX_FN_SERIAL  = 2'h1,
		SPAMX_FN_CAPTURE = 2'h2
	} spamx_fn_t;

	localparam logic [1:0] FN_RESET = 2'h0;
	localparam logic [3:0] GPIO_OE_RESET  = 4'h0;
	localparam logic [3:0] GPIO_OUT_RESET = 4'h0;

	// Low-frequency reference is counted in reference edges, not core cycles
	localparam int ALT_RESET_MIN_REF_CYCLES = 3;
	// Debug acknowledge length in core cycles
	localparam int DEBUG_ACK_CYCLES = 3;
	localparam int ACK_CNT_W = 2;
endpackage : spamx_pkg

/* spamx_sync.sv */
// Three-stage synchroniser with agreement of the last two stages.
// Assumes input is asynchronous to clk; rst_n is already synchronous-released.
`timescale 1ns/10ps
module spamx_sync #(
	parameter logic INIT = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} spamx_sync_st_t;

	spamx_sync_st_t st_r;
	spamx_sync_st_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// Change only counts once stages two and three agree
		if (st_r.s2 == st_r.s3) begin
			st_nxt.q = st_r.s3;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {INIT, INIT, INIT, INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.q;
endmodule : spamx_sync

/* spamx_mux.sv */
// Pin multiplexer for serial port A: normal serial/capture/GPIO or alternate
// JTAG data, external reset and debug-event functions.
// Assumes a 200 MHz clk; the UART, TAP, timers and debug logic are outside.
//
// Functional notes
// R1: Select low routes normal serial functions
// R2: Select high routes JTAG, reset, debug
// R3: Unprogrammed pins act as GPIO
// R4: Reset leaves pins as inputs, drivers off
// R5: JTAG data out drives only in shift
// R6: JTAG data in sampled on test clock
// R7: Primary JTAG data pins disconnected when alternate
// R8: Alternate reset needs three reference-clock lows
// R9: Primary reset ignored when alternate enabled
// R10: External low on debug pin requests debug
// R11: Debug entry pulses open-drain acknowledge
// R12: Primary debug pin disabled when alternate
// R13: Receive pin feeds capture input one
// R14: Request pin feeds capture input two
// R15: Normal mode carries serial out, request
// R16: Clear pin is handshake input or GPIO
// R17: Pulls disconnected while pin drives
// R18: Output enable only from selected function
`timescale 1ns/10ps
module spamx_mux (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       pin_function_select,
	input  wire logic [7:0] pin_fn_cfg,
	input  wire logic [3:0] gpio_out,
	input  wire logic [3:0] gpio_oe,
	output logic      [3:0] gpio_in,
	input  wire logic [3:0] pad_in,
	output logic      [3:0] pad_out,
	output logic      [3:0] pad_oe,
	output logic      [3:0] pad_pull_en,
	input  wire logic       port_a_serial_out,
	output logic            port_a_serial_in,
	input  wire logic       port_a_send_request,
	output logic            port_a_send_clear,
	output logic            capture_input_one,
	output logic            capture_input_two,
	input  wire logic       tap_data_out,
	input  wire logic       tap_shift_state,
	output logic            tap_data_in,
	input  wire logic       primary_data_in,
	input  wire logic       primary_data_out_oe,
	output logic            primary_data_out_en,
	input  wire logic       low_freq_ref_clock,
	input  wire logic       primary_reset_n,
	output logic            chip_reset_n,
	input  wire logic       debug_entered,
	input  wire logic       primary_debug_in_n,
	output logic            primary_debug_en,
	output logic            debug_request
);
	typedef struct packed {
		logic                                sel;
		logic                                ref_prev;
		logic [1:0]                          low_cnt;
		logic                                rst_n;
		logic [spamx_pkg::ACK_CNT_W-1:0]     ack_cnt;
	} spamx_st_t;

	spamx_st_t st_r;
	spamx_st_t st_nxt;
	logic      rst_s1_r;
	logic      rst_s2_r;
	logic [3:0] pin_s;
	logic      sel_s;
	logic      ref_s;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < spamx_pkg::NUM_PINS; gi++) begin : g_sync
			spamx_sync #(.INIT(1'b1)) u_pin (
				.clk   (clk),
				.rst_n (rst_s2_r),
				.din   (pad_in[gi]),
				.dout  (pin_s[gi])
			);
		end
	endgenerate

	spamx_sync #(.INIT(1'b0)) u_sel (
		.clk   (clk),
		.rst_n (rst_s2_r),
		.din   (pin_function_select),
		.dout  (sel_s)
	);

	spamx_sync #(.INIT(1'b0)) u_ref (
		.clk   (clk),
		.rst_n (rst_s2_r),
		.din   (low_freq_ref_clock),
		.dout  (ref_s)
	);

	function automatic logic [1:0] fn_of(input logic [7:0] cfg, input int idx);
		fn_of = cfg[2*idx +: 2];
	endfunction : fn_of

	// Alternate reset qualifier and debug acknowledge stretcher
	always_comb begin
		st_nxt          = st_r;
		st_nxt.sel      = sel_s;
		st_nxt.ref_prev = ref_s;
		if (!st_r.sel || pin_s[spamx_pkg::PIN_REQ]) begin
			st_nxt.low_cnt = 2'h0;
			st_nxt.rst_n   = 1'b1;
		end else if (ref_s && !st_r.ref_prev) begin
			// Only reference-clock rising edges count toward validity
			if (st_r.low_cnt == 2'(spamx_pkg::ALT_RESET_MIN_REF_CYCLES - 1)) begin
				st_nxt.rst_n = 1'b0; // R8
			end else begin
				st_nxt.low_cnt = st_r.low_cnt + 2'h1;
			end
		end
		if (debug_entered && st_r.sel) begin
			st_nxt.ack_cnt = spamx_pkg::ACK_CNT_W'(spamx_pkg::DEBUG_ACK_CYCLES); // R11
		end else if (st_r.ack_cnt != '0) begin
			st_nxt.ack_cnt = st_r.ack_cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_s2_r) begin
		if (!rst_s2_r) begin
			st_r <= '{sel: 1'b0, ref_prev: 1'b0, low_cnt: 2'h0, rst_n: 1'b1, ack_cnt: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Pin routing; output enables come only from the selected function
	always_comb begin
		logic [1:0] fn_out;
		logic [1:0] fn_in;
		logic [1:0] fn_req;
		logic [1:0] fn_clr;
		fn_out  = fn_of(pin_fn_cfg, spamx_pkg::PIN_OUT);
		fn_in   = fn_of(pin_fn_cfg, spamx_pkg::PIN_IN);
		fn_req  = fn_of(pin_fn_cfg, spamx_pkg::PIN_REQ);
		fn_clr  = fn_of(pin_fn_cfg, spamx_pkg::PIN_CLEAR);
		pad_out = gpio_out;
		pad_oe  = gpio_oe; // R3 R4
		gpio_in = pin_s;
		port_a_serial_in  = 1'b1;
		port_a_send_clear = 1'b1;
		capture_input_one = 1'b1;
		capture_input_two = 1'b1;
		tap_data_in       = primary_data_in;
		if (st_r.sel) begin // R2
			pad_out = 4'h0;
			pad_oe  = 4'h0; // R18
			pad_out[spamx_pkg::PIN_OUT] = tap_data_out;
			pad_oe[spamx_pkg::PIN_OUT]  = tap_shift_state; // R5
			tap_data_in = pin_s[spamx_pkg::PIN_IN]; // R6 R7
			pad_oe[spamx_pkg::PIN_CLEAR] = (st_r.ack_cnt != '0); // R11
		end else begin // R1
			if (fn_out == spamx_pkg::SPAMX_FN_SERIAL) begin
				pad_out[spamx_pkg::PIN_OUT] = port_a_serial_out; // R15
				pad_oe[spamx_pkg::PIN_OUT]  = 1'b1;
			end
			if (fn_in == spamx_pkg::SPAMX_FN_SERIAL) begin
				pad_oe[spamx_pkg::PIN_IN] = 1'b0;
				port_a_serial_in = pin_s[spamx_pkg::PIN_IN];
			end else if (fn_in == spamx_pkg::SPAMX_FN_CAPTURE) begin
				pad_oe[spamx_pkg::PIN_IN] = 1'b0;
				capture_input_one = pin_s[spamx_pkg::PIN_IN]; // R13
			end
			if (fn_req == spamx_pkg::SPAMX_FN_SERIAL) begin
				pad_out[spamx_pkg::PIN_REQ] = port_a_send_request; // R15
				pad_oe[spamx_pkg::PIN_REQ]  = 1'b1;
			end else if (fn_req == spamx_pkg::SPAMX_FN_CAPTURE) begin
				pad_oe[spamx_pkg::PIN_REQ] = 1'b0;
				capture_input_two = pin_s[spamx_pkg::PIN_REQ]; // R14
			end
			if (fn_clr == spamx_pkg::SPAMX_FN_SERIAL) begin
				pad_oe[spamx_pkg::PIN_CLEAR] = 1'b0;
				port_a_send_clear = pin_s[spamx_pkg::PIN_CLEAR]; // R16
			end
		end
	end

	assign pad_pull_en         = ~pad_oe; // R17
	assign primary_data_out_en = primary_data_out_oe && !st_r.sel; // R7
	assign chip_reset_n        = st_r.sel ? st_r.rst_n : primary_reset_n; // R9
	assign primary_debug_en    = !st_r.sel; // R12
	assign debug_request       = st_r.sel ? !pin_s[spamx_pkg::PIN_CLEAR] : !primary_debug_in_n; // R10

	a_tdo_shift_only: assert property (@(posedge clk) disable iff (!rst_s2_r) // R5
		st_r.sel |-> (pad_oe[spamx_pkg::PIN_OUT] == tap_shift_state))
		else $error("data out enable not tied to shift state");

	a_alt_no_gpio: assert property (@(posedge clk) disable iff (!rst_s2_r) // R18
		st_r.sel |-> (pad_oe[spamx_pkg::PIN_IN] == 1'b0) && (pad_oe[spamx_pkg::PIN_REQ] == 1'b0))
		else $error("alternate input pin driven");

	sequence s_dbg_enter;
		debug_entered && st_r.sel;
	endsequence
	a_dbg_ack_len: assert property (@(posedge clk) disable iff (!rst_s2_r) // R11
		s_dbg_enter ##1 !debug_entered |=> pad_oe[spamx_pkg::PIN_CLEAR] [*2])
		else $error("debug acknowledge too short");

	a_dbg_od_low: assert property (@(posedge clk) disable iff (!rst_s2_r) // R11
		st_r.sel && pad_oe[spamx_pkg::PIN_CLEAR] |-> !pad_out[spamx_pkg::PIN_CLEAR])
		else $error("debug pin driven high");

	a_pull_off: assert property (@(posedge clk) disable iff (!rst_s2_r) // R17
		(pad_oe & pad_pull_en) == 4'h0)
		else $error("pull left on while driving");

	a_prim_rst_ign: assert property (@(posedge clk) disable iff (!rst_s2_r) // R9
		st_r.sel && $fell(primary_reset_n) && st_r.rst_n |-> chip_reset_n)
		else $error("primary reset honoured in alternate mode");

	a_tdi_route: assert property (@(posedge clk) disable iff (!rst_s2_r) // R7
		st_r.sel |-> (tap_data_in == pin_s[spamx_pkg::PIN_IN]) && !primary_data_out_en)
		else $error("primary data pins still connected");

	a_alt_rst_min: assert property (@(posedge clk) disable iff (!rst_s2_r) // R8
		$fell(st_r.rst_n) |-> st_r.sel && $past(st_r.low_cnt) == 2'h2)
		else $error("alternate reset taken too early");

	a_norm_txd: assert property (@(posedge clk) disable iff (!rst_s2_r) // R15
		!st_r.sel && pin_fn_cfg[1:0] == 2'h1 |-> pad_oe[0] && pad_out[0] == port_a_serial_out)
		else $error("serial out not routed");
endmodule : spamx_mux

/* spamx_pad_model.sv */
// Far-side model of the four port pins: modem, tester or command converter.
// Assumes pins 1 and 3 carry pull-ups; pins 0 and 2 have none.
`timescale 1ns/10ps
module spamx_pad_model (
	input  wire logic       clk,
	input  wire logic [3:0] pad_out,
	input  wire logic [3:0] pad_oe,
	input  wire logic [3:0] pad_pull_en,
	input  wire logic [3:0] ext_oe,
	input  wire logic [3:0] ext_val,
	output logic      [3:0] pad_in
);
	logic float_r = 1'b0;
	// An undriven pin without a pull must not settle to a tidy level
	always @(posedge clk) begin
		float_r <= ~float_r;
	end
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pad_oe[i] && ext_oe[i])
				pad_in[i] = pad_out[i] & ext_val[i];
			else if (ext_oe[i])
				pad_in[i] = ext_val[i];
			else if (pad_oe[i])
				pad_in[i] = pad_out[i];
			else if (pad_pull_en[i] && (i == 1 || i == 3))
				pad_in[i] = 1'b1;
			else
				pad_in[i] = float_r;
		end
	end
endmodule : spamx_pad_model

/* spamx_mux_tb_top.sv */
// Self-checking bench for the port A pin multiplexer.
// Assumes spamx_pad_model on the pins; waits cover the 4-cycle input synchronisers.
`timescale 1ns/10ps
module spamx_mux_tb_top;
	logic       clk = 0, arst_n = 0, sel = 0, ref_clk = 0, so = 0, rq = 0, tdo = 0, tsh = 0;
	logic       pdi = 0, pdo_oe = 0, prst_n = 1, dbe = 0, si, cl, c1, c2, tdi, pdo_en, crst_n;
	logic       pdbg_en, dreq, pdbg_n = 1;
	logic [7:0] cfg = 8'h00;
	logic [3:0] gout = 4'h0, goe = 4'h0, ext_oe = 4'h0, ext_val = 4'h0, gin, pin, pout, poe, ppull;
	int         fail_count = 0, n_tests = 0, cycles = 0;

	spamx_mux uut (.clk(clk), .arst_n(arst_n), .pin_function_select(sel), .pin_fn_cfg(cfg),
		.gpio_out(gout), .gpio_oe(goe), .gpio_in(gin), .pad_in(pin), .pad_out(pout), .pad_oe(poe),
		.pad_pull_en(ppull), .port_a_serial_out(so), .port_a_serial_in(si), .port_a_send_request(rq),
		.port_a_send_clear(cl), .capture_input_one(c1), .capture_input_two(c2), .tap_data_out(tdo),
		.tap_shift_state(tsh), .tap_data_in(tdi), .primary_data_in(pdi), .primary_data_out_oe(pdo_oe),
		.primary_data_out_en(pdo_en), .low_freq_ref_clock(ref_clk), .primary_reset_n(prst_n),
		.chip_reset_n(crst_n), .debug_entered(dbe), .primary_debug_in_n(pdbg_n),
		.primary_debug_en(pdbg_en), .debug_request(dreq));
	spamx_pad_model pads (.clk(clk), .pad_out(pout), .pad_oe(poe), .pad_pull_en(ppull),
		.ext_oe(ext_oe), .ext_val(ext_val), .pad_in(pin));

	always #2.5 clk = ~clk;

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step

	task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize

	task automatic ref_pulse();
		ref_clk = 1;
		step(4);
		ref_clk = 0;
		step(4);
	endtask : ref_pulse

	task automatic t_normal();
		cfg = 8'h69; ext_oe = 4'he; rq = 1; so = 1; step(8);
		check("pad_oe", poe, 4'h1);
		check("pad_out0", {3'h0, pout[0]}, 4'h1);
		check("pull_en", ppull, 4'he);
		check("capture", {1'b0, si, c1, c2}, 4'h4);
		check("clear", {3'h0, cl}, 4'h0);
		cfg = 8'h55; ext_oe = 4'ha; so = 0; rq = 1; step(8);
		check("pad_oe", poe, 4'h5);
		check("pad_out", pout & 4'h5, 4'h4);
		check("serial_in", {3'h0, si}, 4'h0);
		cfg = 8'h00; goe = 4'hc; gout = 4'h4; ext_oe = 4'h3; ext_val = 4'h2; pdo_oe = 1; pdbg_n = 0; step(8);
		check("gpio_oe", poe, 4'hc);
		check("gpio_out", pout & 4'hc, 4'h4);
		check("gpio_in", gin, 4'h6);
		check("clear_idle", {c1, c2, si, cl}, 4'hf);
		check("norm_primaries", {pdo_en, pdbg_en, crst_n, dreq}, 4'hf);
		$display("normal mode done");
	endtask : t_normal

	task automatic t_alt();
		sel = 1; cfg = 8'h55; goe = 4'hf; ext_oe = 4'h6; ext_val = 4'h6; pdo_oe = 1; step(8);
		check("alt_oe", poe, 4'h0);
		check("tap_in", {3'h0, tdi}, 4'h1);
		// Primary reset falls only once the alternate select has settled
		prst_n = 0; step(2);
		check("primaries", {1'b0, pdo_en, pdbg_en, crst_n}, 4'h1);
		tsh = 1; tdo = 1; step(2);
		check("tap_out", poe & pout, 4'h1);
		tsh = 0; ext_val = 4'h2; step(8);
		ref_pulse();
		ref_pulse();
		check("rst_early", {3'h0, crst_n}, 4'h1);
		ref_pulse();
		check("rst_taken", {3'h0, crst_n}, 4'h0);
		ext_val = 4'h6; step(8);
		check("rst_release", {3'h0, crst_n}, 4'h1);
		$display("alternate mode done");
	endtask : t_alt

	task automatic t_debug();
		logic [3:0] n;
		ext_oe = 4'he; step(8);
		check("dbg_req", {3'h0, dreq}, 4'h1);
		ext_oe = 4'h6; step(8);
		check("dbg_idle", {3'h0, dreq}, 4'h0);
		dbe = 1; step(1);
		dbe = 0; n = 0;
		repeat (10) begin
			if (poe[3] === 1'b1 && pout[3] === 1'b0)
				n++;
			step(1);
		end
		check("ack_len", n, 4'(spamx_pkg::DEBUG_ACK_CYCLES));
		$display("debug event done");
	endtask : t_debug

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			summarize();
		end
	end

	initial begin
		step(2);
		arst_n = 1; step(10);
		check("reset_oe", poe, 4'h0);
		check("reset_pull", ppull, 4'hf);
		$display("reset done");
		t_normal();
		t_alt();
		t_debug();
		summarize();
	end
endmodule : spamx_mux_tb_top
